/* File: core/pll_control_register_bank.sv */
// Control and test register bank of the synthesizer digital section
`include "pll_ctrl_regs.svh"

module pll_control_register_bank
    import pll_ctrl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_b,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe_b,
    input  wire logic        div_ref_clk,
    input  wire logic        div_fb_clk,
    input  wire logic        lock_cond,
    input  wire logic        lock_window_ok,
    input  wire logic        vco_cal_active,
    input  wire logic        oscillator_bias_override,
    input  wire logic        delay_strobe_pin,
    input  wire logic        delay_adjust_pin,
    output logic             ref_clk_digital,
    output logic             fb_clk_digital,
    output logic             adc_clk,
    output logic             lock_detect,
    output logic             loss_of_lock,
    output logic             test_out,
    output logic             test_out_oe_b,
    output pump_ctrl_t       pump_ctrl,
    output delay_ctrl_t      delay_ctrl,
    output phase_step_t      phase_step,
    output logic [15:0]      phase_offset,
    output logic [15:0]      freq_count,
    output logic [5:0]       oscillator_bias,
    output logic             bias_from_register
);

    // ------------
    // Input synchronisers
    // ------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign pin_raw = {spi_sclk, spi_cs_b, spi_sdi, div_ref_clk, div_fb_clk,
                      lock_cond, lock_window_ok, delay_strobe_pin, delay_adjust_pin};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 9'h080;
            sync2_q <= 9'h080;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    logic sclk_s;
    logic cs_b_s;
    logic sdi_s;
    logic ref_s;
    logic fb_s;
    logic cond_s;
    logic win_s;
    logic strobe_s;
    logic adjust_s;
    assign {sclk_s, cs_b_s, sdi_s, ref_s, fb_s, cond_s, win_s, strobe_s, adjust_s} = sync2_q;

    // ------------
    // Edge detection
    // ------------
    logic sclk_d1_q;
    logic ref_d1_q;
    logic fb_d1_q;
    logic strobe_d1_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d1_q   <= 1'b0;
            ref_d1_q    <= 1'b0;
            fb_d1_q     <= 1'b0;
            strobe_d1_q <= 1'b0;
        end else begin
            sclk_d1_q   <= sclk_s;
            ref_d1_q    <= ref_s;
            fb_d1_q     <= fb_s;
            strobe_d1_q <= strobe_s;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_s & ~sclk_d1_q & ~cs_b_s;
    assign sclk_fall = ~sclk_s & sclk_d1_q & ~cs_b_s;

    // ------------
    // Serial port
    // ------------
    logic [4:0]  bit_cnt_q;
    logic [22:0] shift_in_q;
    logic [23:0] frame;
    logic        rd_phase_q;
    logic [7:0]  sdo_shift_q;
    logic        sdo_q;
    logic        wr_pulse;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
    logic [14:0] rd_addr;
    logic [7:0]  rd_data;
    assign frame    = {shift_in_q, sdi_s};
    assign wr_pulse = sclk_rise & (bit_cnt_q == `SPI_FRAME_LAST) & ~frame[23];
    assign wr_addr  = frame[22:8];
    assign wr_data  = frame[7:0];
    assign rd_addr  = frame[14:0];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_q  <= 5'h00;
            shift_in_q <= 23'h000000;
        end else if (cs_b_s) begin
            bit_cnt_q  <= 5'h00;
        end else if (sclk_rise) begin
            shift_in_q <= frame[22:0];
            bit_cnt_q  <= (bit_cnt_q == `SPI_FRAME_LAST) ? 5'h00 : bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_phase_q  <= 1'b0;
            sdo_shift_q <= 8'h00;
            sdo_q       <= 1'b0;
        end else if (cs_b_s) begin
            rd_phase_q  <= 1'b0;
        end else if (sclk_rise && bit_cnt_q == `SPI_CMD_LAST) begin
            rd_phase_q  <= frame[`SPI_RD_BIT];
            sdo_shift_q <= rd_data;
        end else if (sclk_rise && bit_cnt_q == `SPI_FRAME_LAST) begin
            rd_phase_q  <= 1'b0;
        end else if (sclk_fall && rd_phase_q) begin
            sdo_q       <= sdo_shift_q[7];
            sdo_shift_q <= {sdo_shift_q[6:0], 1'b0};
        end
    end

    assign spi_sdo      = sdo_q;
    assign spi_sdo_oe_b = ~(rd_phase_q & ~cs_b_s);

    // ------------
    // Register file
    // ------------
    logic [7:0] regs_q [`REG_COUNT];
    logic       wr_hit;
    logic [3:0] wr_idx;
    logic       rd_hit;
    logic [3:0] rd_idx;
    assign wr_hit = (wr_addr >= `ADR_LOCK_SETUP) && (wr_addr <= `ADR_BIAS_VALUE);
    assign wr_idx = 4'(wr_addr - `ADR_LOCK_SETUP);
    assign rd_hit = (rd_addr >= `ADR_LOCK_SETUP) && (rd_addr <= `ADR_BIAS_VALUE);
    assign rd_idx = 4'(rd_addr - `ADR_LOCK_SETUP);
    assign rd_data = rd_hit ? regs_q[rd_idx] : 8'h00;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs_q[i] <= `REG_RESET;
            end
        end else if (wr_pulse && wr_hit) begin
            regs_q[wr_idx] <= wr_data;
        end
    end

    logic [7:0] r_lock;
    logic [7:0] r_gate;
    logic [7:0] r_test;
    logic [7:0] r_refsel;
    logic [7:0] r_sync;
    logic [7:0] r_mode;
    logic [7:0] r_amount;
    logic [7:0] r_apply;
    logic [7:0] r_bias;
    assign r_lock   = regs_q[4'(`ADR_LOCK_SETUP   - `ADR_LOCK_SETUP)];
    assign r_gate   = regs_q[4'(`ADR_CLOCK_GATING - `ADR_LOCK_SETUP)];
    assign r_test   = regs_q[4'(`ADR_TEST_OUTPUT  - `ADR_LOCK_SETUP)];
    assign r_refsel = regs_q[4'(`ADR_REF_SELECT   - `ADR_LOCK_SETUP)];
    assign r_sync   = regs_q[4'(`ADR_SYNC_SYSRST  - `ADR_LOCK_SETUP)];
    assign r_mode   = regs_q[4'(`ADR_DELAY_MODE   - `ADR_LOCK_SETUP)];
    assign r_amount = regs_q[4'(`ADR_PHASE_AMOUNT - `ADR_LOCK_SETUP)];
    assign r_apply  = regs_q[4'(`ADR_PHASE_APPLY  - `ADR_LOCK_SETUP)];
    assign r_bias   = regs_q[4'(`ADR_BIAS_VALUE   - `ADR_LOCK_SETUP)];

    logic sys_rst;
    logic ld_rst;
    assign sys_rst = r_sync[`B_SYS_RESET];
    assign ld_rst  = r_gate[`B_LD_RESET] | sys_rst;

    // ------------
    // Digital clock gating and halving
    // ------------
    logic ref_gated;
    logic fb_gated;
    logic ref_edge;
    logic fb_edge;
    logic ref_half_q;
    logic fb_half_q;
    logic halve;
    assign ref_gated = ref_s & r_gate[`B_REF_GATE_EN];
    assign fb_gated  = fb_s & r_gate[`B_FB_GATE_EN] & ~r_refsel[`B_FB_MUTE];
    assign ref_edge  = ref_s & ~ref_d1_q & r_gate[`B_REF_GATE_EN];
    assign fb_edge   = fb_s & ~fb_d1_q & r_gate[`B_FB_GATE_EN] & ~r_refsel[`B_FB_MUTE];
    assign halve     = r_sync[`B_CAL_HALVE] & vco_cal_active;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_half_q <= 1'b0;
            fb_half_q  <= 1'b0;
        end else if (sys_rst) begin
            ref_half_q <= 1'b0;
            fb_half_q  <= 1'b0;
        end else begin
            ref_half_q <= ref_half_q ^ ref_edge;
            fb_half_q  <= fb_half_q ^ fb_edge;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_clk_digital <= 1'b0;
            fb_clk_digital  <= 1'b0;
            adc_clk         <= 1'b0;
        end else begin
            ref_clk_digital <= halve ? ref_half_q : ref_gated;
            fb_clk_digital  <= halve ? fb_half_q : fb_gated;
            adc_clk         <= ref_gated & r_sync[`B_ADC_CLK_EN];
        end
    end

    // ------------
    // Lock detector
    // ------------
    logic [4:0] lock_cnt_q;
    logic       locked_q;
    logic       cycle_good;
    logic [4:0] lock_target;
    assign lock_target = r_lock[`B_LOCK_COUNT_HI:0];
    assign cycle_good  = r_gate[`B_WIN_EN] ? (cond_s & win_s) : cond_s;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt_q <= 5'h00;
            locked_q   <= 1'b0;
        end else if (ld_rst) begin
            lock_cnt_q <= 5'h00;
            locked_q   <= 1'b0;
        end else if (ref_edge) begin
            if (!cycle_good) begin
                lock_cnt_q <= 5'h00;
                locked_q   <= 1'b0;
            end else if (lock_cnt_q >= lock_target) begin
                locked_q   <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q + 5'h01;
            end
        end
    end

    logic locked_d1_q;
    logic lol_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            locked_d1_q <= 1'b0;
            lol_q       <= 1'b0;
        end else begin
            locked_d1_q <= locked_q;
            if (locked_d1_q && !locked_q && !ld_rst && r_gate[`B_LOL_EN]) begin
                lol_q <= 1'b1;
            end else if (ld_rst || !r_gate[`B_LOL_EN]) begin
                lol_q <= 1'b0;
            end
        end
    end

    assign lock_detect  = locked_q;
    assign loss_of_lock = lol_q;

    // ------------
    // Test output selector
    // ------------
    test_sel_t sel;
    always_comb begin
        unique case (r_test[`B_SEL_HI:`B_SEL_LO])
            4'h1:    sel = SEL_LOCK;
            4'h4:    sel = SEL_REF_HALF;
            4'h5:    sel = SEL_FB_HALF;
            4'h0:    sel = SEL_HIGH_Z;
            4'h8:    sel = SEL_HIGH;
            default: sel = SEL_LOW;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            test_out      <= 1'b0;
            test_out_oe_b <= 1'b1;
        end else begin
            test_out_oe_b <= (sel == SEL_HIGH_Z);
            unique case (sel)
                SEL_LOCK:     test_out <= locked_q;
                SEL_REF_HALF: test_out <= ref_half_q;
                SEL_FB_HALF:  test_out <= fb_half_q;
                SEL_HIGH:     test_out <= 1'b1;
                SEL_LOW:      test_out <= 1'b0;
                SEL_HIGH_Z:   test_out <= 1'b0;
            endcase
        end
    end

    // ------------
    // Pump test, delays and bias
    // ------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pump_ctrl <= '0;
        end else begin
            pump_ctrl.test_active <= r_test[`B_PUMP_TEST];
            pump_ctrl.force_lower <= r_test[`B_PUMP_TEST] & r_test[`B_PUMP_LOWER];
            pump_ctrl.force_raise <= r_test[`B_PUMP_TEST] & r_test[`B_PUMP_RAISE];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_ctrl <= '0;
        end else begin
            delay_ctrl.sync_dly    <= r_sync[`B_SYNC_DLY_HI:`B_SYNC_DLY_LO];
            delay_ctrl.ref_dly     <= r_apply[`B_REF_DLY_HI:`B_REF_DLY_LO];
            delay_ctrl.fb_dly      <= r_apply[`B_FB_DLY_HI:`B_FB_DLY_LO];
            delay_ctrl.sigma_delta <= r_mode[`B_DLY_METHOD];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            oscillator_bias    <= 6'h00;
            bias_from_register <= 1'b0;
        end else begin
            bias_from_register <= oscillator_bias_override;
            if (oscillator_bias_override) begin
                oscillator_bias <= r_bias[`B_BIAS_HI:0];
            end
        end
    end

    // ------------
    // Phase adjustment
    // ------------
    logic auto_align;
    logic apply_req;
    logic apply_add;
    assign auto_align = r_mode[`B_AUTO_ALIGN];
    assign apply_req  = auto_align ? (strobe_s & ~strobe_d1_q)
                      : (wr_pulse && wr_hit && wr_addr == `ADR_PHASE_APPLY
                         && wr_data[`B_APPLY]);
    assign apply_add  = auto_align ? adjust_s : r_mode[`B_DIRECTION];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_step   <= '0;
            phase_offset <= 16'h0000;
        end else if (sys_rst) begin
            phase_step   <= '0;
            phase_offset <= 16'h0000;
        end else begin
            phase_step.valid <= apply_req;
            if (apply_req) begin
                phase_step.add    <= apply_add;
                phase_step.amount <= r_amount;
                phase_offset      <= apply_add ? phase_offset + {8'h00, r_amount}
                                               : phase_offset - {8'h00, r_amount};
            end
        end
    end

    // ------------
    // Frequency counter test mode
    // ------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_count <= 16'h0000;
        end else if (sys_rst || r_apply[`B_CNT_RESET]) begin
            freq_count <= 16'h0000;
        end else if (fb_edge) begin
            freq_count <= freq_count + 16'h0001;
        end
    end

endmodule

/* File: core/pll_ctrl_pkg.sv */
// Types shared by the control bank and its users
package pll_ctrl_pkg;

    typedef enum logic [5:0] {
        SEL_HIGH_Z   = 6'b000001,
        SEL_LOCK     = 6'b000010,
        SEL_REF_HALF = 6'b000100,
        SEL_FB_HALF  = 6'b001000,
        SEL_LOW      = 6'b010000,
        SEL_HIGH     = 6'b100000
    } test_sel_t;

    typedef struct packed {
        logic       test_active;
        logic       force_lower;
        logic       force_raise;
    } pump_ctrl_t;

    typedef struct packed {
        logic [2:0] sync_dly;
        logic [2:0] ref_dly;
        logic [2:0] fb_dly;
        logic       sigma_delta;
    } delay_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       add;
        logic [7:0] amount;
    } phase_step_t;

endpackage

/* File: core/pll_ctrl_regs.svh */
// Register offsets, field positions and reset values of the control bank
// Operation
// - Selector code 0000 floats test pin, 0111 drives low, 1000 drives high.
// - Selector 0001 lock output, 0100 reference clock halved, 0101 feedback halved.
// - With pump test enable set, lower and raise bits force the pump directly.
// - Lock detector reset bit held at 1 keeps detector unlocked.
// - Loss-of-lock detection runs only while its enable bit is 1.
// - Lock pulse window applies only while its enable bit is 1.
// - Feedback and reference clocks reach digital logic only when their enables are set.
// - Feedback mute bit blocks the divider output toward digital logic.
// - System reset bit holds digital logic at power-on state, sparing port and registers.
// - Temperature converter clock runs only while its enable bit is 1.
// - Halving bit divides both digital clocks by two during oscillator calibration.
// - Bits 7 to 5 select the synchronization path input delay.
// - Delay method bit chooses pump bleed at 0, sigma-delta at 1.
// - Auto-align 0 applies shift by register write; 1 by strobe and adjust pins.
// - Direction bit 0 subtracts programmed phase, 1 adds it.
// - Writing apply bit 1 applies the eight-bit phase amount.
// - Two three-bit fields set reference and feedback path delays.
// - Bit 0 of the apply register resets the frequency counter.
// - Six-bit bias value feeds the oscillator bias while override is set.
// - All bank registers reset to zero.
// - Lock asserts after programmed count of consecutive good comparison cycles; the code asserts on the next good cycle, at count plus one.
`ifndef PLL_CTRL_REGS_SVH
`define PLL_CTRL_REGS_SVH

// ------------
// Register offsets
// ------------
`define ADR_LOCK_SETUP     15'h002c
`define ADR_CLOCK_GATING   15'h002d
`define ADR_TEST_OUTPUT    15'h002e
`define ADR_REF_BUFFER     15'h002f
`define ADR_REF_SELECT     15'h0030
`define ADR_SYNC_SYSRST    15'h0031
`define ADR_DELAY_MODE     15'h0032
`define ADR_PHASE_AMOUNT   15'h0033
`define ADR_PHASE_APPLY    15'h0034
`define ADR_BIAS_VALUE     15'h0035
`define REG_COUNT          10
`define REG_RESET          8'h00

// ------------
// Field positions
// ------------
`define B_LOCK_COUNT_HI    4
`define B_FB_GATE_EN       7
`define B_LOL_EN           5
`define B_WIN_EN           4
`define B_REF_GATE_EN      3
`define B_LD_RESET         2
`define B_SEL_HI           7
`define B_SEL_LO           4
`define B_PUMP_TEST        2
`define B_PUMP_LOWER       1
`define B_PUMP_RAISE       0
`define B_FB_MUTE          7
`define B_SYNC_DLY_HI      7
`define B_SYNC_DLY_LO      5
`define B_SYS_RESET        4
`define B_ADC_CLK_EN       3
`define B_CAL_HALVE        0
`define B_DLY_METHOD       5
`define B_AUTO_ALIGN       4
`define B_DIRECTION        3
`define B_APPLY            7
`define B_REF_DLY_HI       6
`define B_REF_DLY_LO       4
`define B_FB_DLY_HI        3
`define B_FB_DLY_LO        1
`define B_CNT_RESET        0
`define B_BIAS_HI          5

// ------------
// Serial frame layout
// ------------
`define SPI_FRAME_LAST     5'd23
`define SPI_CMD_LAST       5'd15
`define SPI_RD_BIT         15

`endif

/* File: tb/pll_control_register_bank_assertions.sv */
// Port-level concurrent checks for the control register bank
module pll_control_register_bank_assertions
    import pll_ctrl_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        spi_sclk,
    input wire logic        spi_cs_b,
    input wire logic        spi_sdo,
    input wire logic        spi_sdo_oe_b,
    input wire logic        lock_cond,
    input wire logic        oscillator_bias_override,
    input wire logic        lock_detect,
    input wire logic        loss_of_lock,
    input wire phase_step_t phase_step,
    input wire logic [15:0] phase_offset,
    input wire logic [15:0] freq_count,
    input wire logic [5:0]  oscillator_bias,
    input wire logic        bias_from_register
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence cs_idle;
        spi_cs_b [*3];
    endsequence
    sequence lock_fell;
        !lock_detect && ($past(lock_detect) || $past(lock_detect, 2));
    endsequence
    a_sdo_idle_off: assert property (cs_idle |-> spi_sdo_oe_b)
        else $error("sdo driven while deselected");
    a_sdo_stable: assert property ($changed(spi_sdo) && !spi_sdo_oe_b |-> !spi_sclk)
        else $error("sdo changed while serial clock high");
    a_bias_hold: assert property (!$past(oscillator_bias_override) |-> $stable(oscillator_bias))
        else $error("bias moved without override");
    a_bias_copy: assert property ($rose(oscillator_bias_override) |=> bias_from_register)
        else $error("override copy missing");
    a_step_pulse: assert property (phase_step.valid |=> !phase_step.valid)
        else $error("phase step longer than one cycle");
    a_offset_cause: assert property ($changed(phase_offset) && phase_offset != 16'h0000
        |-> phase_step.valid || $past(phase_step.valid))
        else $error("phase offset moved without step");
    a_freq_step: assert property ($changed(freq_count)
        |-> freq_count == $past(freq_count) + 16'h0001 || freq_count == 16'h0000)
        else $error("frequency count jumped");
    a_loss_cause: assert property ($rose(loss_of_lock) |-> lock_fell)
        else $error("loss flag without lock fall");
    a_lock_cause: assert property ($rose(lock_detect) |-> $past(lock_cond, 3))
        else $error("lock without good cycles");
endmodule

bind pll_control_register_bank pll_control_register_bank_assertions chk (
    .core_clk, .rst_b, .spi_sclk, .spi_cs_b, .spi_sdo, .spi_sdo_oe_b, .lock_cond,
    .oscillator_bias_override, .lock_detect, .loss_of_lock, .phase_step, .phase_offset,
    .freq_count, .oscillator_bias, .bias_from_register
);

/* File: tb/pll_control_register_bank_test.sv */
// Self-checking bench for the control register bank
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, sn); end end
module pll_control_register_bank_test
    import pll_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [14:0] a; logic [7:0] d; logic [7:0] e; } row_t;
    localparam row_t ROWS [12] = '{
        '{15'h2c, 8'hff, 8'hff}, '{15'h2d, 8'ha5, 8'ha5}, '{15'h2e, 8'h5a, 8'h5a},
        '{15'h2f, 8'hc3, 8'hc3}, '{15'h30, 8'h3c, 8'h3c}, '{15'h31, 8'hef, 8'hef},
        '{15'h32, 8'h96, 8'h96}, '{15'h33, 8'h69, 8'h69}, '{15'h34, 8'h7f, 8'h7f},
        '{15'h35, 8'hff, 8'hff}, '{15'h36, 8'hff, 8'h00}, '{15'h2b, 8'hff, 8'h00}};
    logic core_clk = 1'b0, rst_b = 1'b0, spi_sclk, spi_cs_b, spi_sdi, spi_sdo, spi_sdo_oe_b;
    logic div_ref_clk, div_fb_clk, lock_cond, lock_window_ok, vco_cal_active;
    logic oscillator_bias_override, delay_strobe_pin, delay_adjust_pin;
    logic ref_clk_digital, fb_clk_digital, adc_clk, lock_detect, loss_of_lock;
    logic test_out, test_out_oe_b, bias_from_register;
    pump_ctrl_t  pump_ctrl;
    delay_ctrl_t delay_ctrl;
    phase_step_t phase_step, last_step;
    logic [15:0] phase_offset, freq_count;
    logic [5:0]  oscillator_bias;
    logic [7:0]  rd;
    logic [3:0]  mon, mon_q;
    int n_fail = 0, total_checks = 0, n_steps = 0;
    int tg [4];
    always #5 core_clk = ~core_clk;
    spi_host_model host (.core_clk, .spi_sclk, .spi_cs_b, .spi_sdi, .spi_sdo);
    pll_control_register_bank dut (.core_clk, .rst_b, .spi_sclk, .spi_cs_b, .spi_sdi, .spi_sdo,
        .spi_sdo_oe_b, .div_ref_clk, .div_fb_clk, .lock_cond, .lock_window_ok, .vco_cal_active,
        .oscillator_bias_override, .delay_strobe_pin, .delay_adjust_pin, .ref_clk_digital,
        .fb_clk_digital, .adc_clk, .lock_detect, .loss_of_lock, .test_out, .test_out_oe_b,
        .pump_ctrl, .delay_ctrl, .phase_step, .phase_offset, .freq_count, .oscillator_bias,
        .bias_from_register);
    assign mon = {test_out, adc_clk, fb_clk_digital, ref_clk_digital};
    always @(posedge core_clk) begin
        for (int i = 0; i < 4; i++)
            if (mon[i] !== mon_q[i])
                tg[i]++;
        mon_q <= mon;
        if (phase_step.valid === 1'b1) begin
            n_steps++;
            last_step = phase_step;
        end
    end
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rd);
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, rd);
        `CHK("read data", e, rd)
    endtask
    task automatic pulses(input int n);
        tg = '{default: 0};
        repeat (n) begin
            {div_ref_clk, div_fb_clk} = 2'h3;
            repeat (4) @(negedge core_clk);
            {div_ref_clk, div_fb_clk} = 2'h0;
            repeat (4) @(negedge core_clk);
        end
        repeat (4) @(negedge core_clk);
    endtask
    task automatic clk_case(input int r, input int f, input int a);
        pulses(4);
        `CHK("ref clock edges", r, tg[0])
        `CHK("fb clock edges", f, tg[1])
        `CHK("adc clock edges", a, tg[2])
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(400_000);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {div_ref_clk, div_fb_clk, lock_cond, vco_cal_active} = 4'h0;
        {oscillator_bias_override, delay_strobe_pin, delay_adjust_pin} = 3'h0;
        lock_window_ok = 1'b1;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK("test enable", 1'b1, test_out_oe_b)
        `CHK("pump", 3'h0, pump_ctrl)
        for (int i = 0; i < 10; i++)
            rd_chk(15'(15'h2c + i), 8'h00);
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd_chk(ROWS[i].a, ROWS[i].e);
        end
        for (int i = 0; i < 10; i++)
            wr(15'(15'h2c + i), 8'h00);
        `CHK("test float", 1'b1, test_out_oe_b)
        wr(15'h2e, 8'h73);
        `CHK("test low", 2'b00, {test_out_oe_b, test_out})
        `CHK("pump normal", 1'b0, pump_ctrl.test_active)
        wr(15'h2e, 8'h86);
        `CHK("test high", 2'b01, {test_out_oe_b, test_out})
        `CHK("pump forced", 3'b110, pump_ctrl)
        wr(15'h31, 8'h08);
        clk_case(0, 0, 0);
        wr(15'h2d, 8'h88);
        wr(15'h2e, 8'h40);
        clk_case(8, 8, 8);
        `CHK("ref half", 4, tg[3])
        wr(15'h31, 8'h01);
        vco_cal_active = 1'b1;
        clk_case(4, 4, 0);
        vco_cal_active = 1'b0;
        wr(15'h30, 8'h80);
        clk_case(8, 0, 0);
        wr(15'h30, 8'h00);
        wr(15'h34, 8'h01);
        `CHK("counter reset", 16'h0000, freq_count)
        wr(15'h34, 8'h00);
        pulses(3);
        `CHK("fb count", 16'h0003, freq_count)
        wr(15'h2e, 8'h10);
        wr(15'h2c, 8'h03);
        wr(15'h2d, 8'ha8);
        lock_cond = 1'b1;
        pulses(3);
        `CHK("lock early", 1'b0, lock_detect)
        pulses(1);
        `CHK("lock set", 1'b1, lock_detect)
        `CHK("lock on pin", 2'b01, {test_out_oe_b, test_out})
        lock_cond = 1'b0;
        pulses(1);
        `CHK("loss set", 2'b01, {lock_detect, loss_of_lock})
        lock_cond = 1'b1;
        wr(15'h2d, 8'hac);
        pulses(5);
        `CHK("lock held reset", 2'b00, {lock_detect, loss_of_lock})
        wr(15'h2d, 8'h88);
        pulses(4);
        lock_cond = 1'b0;
        pulses(1);
        `CHK("loss disabled", 2'b00, {lock_detect, loss_of_lock})
        wr(15'h2d, 8'h98);
        {lock_cond, lock_window_ok} = 2'b10;
        pulses(5);
        `CHK("window", 1'b0, lock_detect)
        n_steps = 0;
        wr(15'h33, 8'h10);
        wr(15'h32, 8'h08);
        wr(15'h34, 8'h80);
        `CHK("step add", 10'h310, last_step)
        `CHK("offset add", 16'h0010, phase_offset)
        wr(15'h33, 8'h05);
        wr(15'h32, 8'h00);
        wr(15'h34, 8'h80);
        `CHK("offset sub", 16'h000b, phase_offset)
        wr(15'h32, 8'h10);
        wr(15'h34, 8'h80);
        `CHK("write ignored", 2, n_steps)
        delay_adjust_pin = 1'b1;
        delay_strobe_pin = 1'b1;
        repeat (6) @(negedge core_clk);
        delay_strobe_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        `CHK("strobe step", 10'h305, last_step)
        `CHK("strobe offset", 16'h0010, phase_offset)
        wr(15'h31, 8'ha0);
        wr(15'h34, 8'h3a);
        wr(15'h32, 8'h20);
        `CHK("delays", 10'b101_011_101_1, delay_ctrl)
        oscillator_bias_override = 1'b1;
        wr(15'h35, 8'h2a);
        `CHK("bias", 7'h6a, {bias_from_register, oscillator_bias})
        oscillator_bias_override = 1'b0;
        wr(15'h35, 8'h15);
        `CHK("bias hold", 6'h2a, oscillator_bias)
        wr(15'h31, 8'h10);
        `CHK("soft offset", 16'h0000, phase_offset)
        `CHK("soft count", 16'h0000, freq_count)
        rd_chk(15'h33, 8'h05);
        wr(15'h31, 8'h00);
        tally_and_finish();
    end
endmodule

/* File: tb/spi_host_model.sv */
// Serial host that sends one register frame per call
module spi_host_model (
    input  wire logic core_clk,
    output logic      spi_sclk,
    output logic      spi_cs_b,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_b = 1'b1;
        spi_sdi  = 1'b0;
    end
    task automatic xfer(input logic rw, input logic [14:0] adr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rw, adr, wd};
        rdat = 8'h00;
        @(negedge core_clk);
        spi_cs_b = 1'b0;
        for (int b = 23; b >= 0; b--) begin
            spi_sdi = frame[b];
            repeat (4) @(negedge core_clk);
            if (b < 8)
                rdat[b] = spi_sdo;
            spi_sclk = 1'b1;
            repeat (4) @(negedge core_clk);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        spi_cs_b = 1'b1;
        spi_sdi  = ~spi_sdi;
        repeat (4) @(negedge core_clk);
    endtask
endmodule
